//--- hdl/mad_decoder.sv
// memory address decoder: register file, program and data spaces
// What this block does
// - decode 4096-byte register file with 12-bit address for reads and writes
// - route addresses F00h-FFFh to the control register section
// - reserved control addresses read undefined; software should not write them
// - on-chip ram sits contiguously from 000h, 256 bytes to 1KB
// - holes between ram and control page read undefined, writes ignored
// - 64KB program space, 16-bit address, flash from zero, 1KB to 8KB
// - program reads beyond implemented flash return FFh
// - program writes beyond implemented flash are discarded
// - option bits, reset, watchdog and illegal-trap vectors at 0000h-0007h
// - interrupt vectors 0008h-0037h, oscillator traps 0038h-003Dh, code after
// - data memory space not implemented; its accesses reach no storage
// - bit 7 of flash page select enables the information area overlay
// - overlay enabled: program reads FE00h-FF7Fh return information area
// - the information area is read-only on every path
// - info layout: option bits, 20-char part id, reserved, calibration data
// - register file has a control section and a general-purpose section
`timescale 1ns/1ps
`include "mad_params.svh"
module mad_decoder #(
  parameter int RAM_BYTES = `MAD_RAM_BYTES_DFLT,
  parameter int FLASH_BYTES = `MAD_FLASH_BYTES_DFLT
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`MAD_RF_AW-1:0] rfAddr,
  input wire logic rfRead,
  input wire logic rfWrite,
  input wire logic [7:0] rfWrData,
  output logic [7:0] rfRdData,
  output logic rfRdValid,
  output mad_pkg::mad_rf_region_e rfRegion,
  output logic [7:0] ctlAddr,
  output logic ctlRead,
  output logic ctlWrite,
  output logic [7:0] ctlWrData,
  input wire logic [7:0] ctlRdData,
  input wire logic ctlDecoded,
  input wire logic [`MAD_PM_AW-1:0] pmAddr,
  input wire logic pmRead,
  input wire logic pmWrite,
  input wire logic [7:0] pmWrData,
  output logic [7:0] pmRdData,
  output logic pmRdValid,
  output mad_pkg::mad_pm_region_e pmRegion,
  input wire logic [7:0] flashPageSel,
  output logic [`MAD_PM_AW-1:0] flashAddr,
  output logic flashRead,
  output logic flashWrite,
  output logic [7:0] flashWrData,
  input wire logic [7:0] flashRdData,
  input wire logic dmRead,
  output logic [7:0] dmRdData,
  output logic dmRdValid
);
  import mad_pkg::*;

  localparam int RAM_AW = $clog2(RAM_BYTES);
  // sizes widened by one bit so that a full-space size still compares
  localparam logic [`MAD_RF_AW:0] RamTop = (`MAD_RF_AW+1)'(RAM_BYTES);
  localparam logic [`MAD_PM_AW:0] FlashTop = (`MAD_PM_AW+1)'(FLASH_BYTES);

  logic ramHit;
  logic ctlHit;
  logic ramWrEn;
  logic [7:0] ramRdData;
  mad_rf_region_e rfKind;
  logic [7:0] next_rfRdData;
  logic next_rfRdValid;
  mad_rf_region_e next_rfRegion;

  logic flashHit;
  logic inWindow;
  logic ovlEn;
  logic infoSel;
  logic [8:0] infoOff;
  logic [7:0] infoByte;
  mad_pm_region_e pmKind;
  logic [7:0] next_pmRdData;
  logic next_pmRdValid;
  mad_pm_region_e next_pmRegion;

  logic [7:0] next_dmRdData;
  logic next_dmRdValid;

  // register file decode: control page wins over a ram range that reaches it
  always_comb begin
    ramHit = ({1'b0, rfAddr} < RamTop);
    ctlHit = (rfAddr >= `MAD_RF_CTL_BASE);
    if (ctlHit) begin
      rfKind = RF_CTL;
    end else if (ramHit) begin
      rfKind = RF_RAM;
    end else begin
      rfKind = RF_HOLE;
    end
  end

  // writes only land in ram when the address is implemented
  assign ramWrEn = rfWrite && (rfKind == RF_RAM);

  mad_ram #(
    .BYTES(RAM_BYTES),
    .AW(RAM_AW)
  ) u_ram (
    .clock(clock),
    .wrEn(ramWrEn),
    .addr(rfAddr[RAM_AW-1:0]),
    .wrData(rfWrData),
    .rdData(ramRdData)
  );

  // control section strobes are combinational so a write lands this cycle
  always_comb begin
    ctlAddr = rfAddr[7:0];
    ctlWrData = rfWrData;
    ctlRead = rfRead && (rfKind == RF_CTL);
    ctlWrite = rfWrite && (rfKind == RF_CTL);
  end

  // register file read answer, one cycle after the request
  always_comb begin
    next_rfRdValid = rfRead;
    next_rfRegion = rfRegion;
    next_rfRdData = rfRdData;
    if (rfRead) begin
      next_rfRegion = rfKind;
      unique case (rfKind)
        RF_RAM: begin
          next_rfRdData = ramRdData;
        end
        RF_CTL: begin
          // reserved control slots give the fixed undefined byte
          next_rfRdData = ctlDecoded ? ctlRdData : `MAD_UNDEF;
        end
        RF_HOLE: begin
          next_rfRdData = `MAD_UNDEF;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rfRdData <= `MAD_RESET_BYTE;
      rfRdValid <= 1'b0;
      rfRegion <= RF_HOLE;
    end else begin
      rfRdData <= next_rfRdData;
      rfRdValid <= next_rfRdValid;
      rfRegion <= next_rfRegion;
    end
  end

  // program memory decode and fixed vector map
  always_comb begin
    flashHit = ({1'b0, pmAddr} < FlashTop);
    inWindow = (pmAddr >= `MAD_INFO_BASE) && (pmAddr <= `MAD_INFO_LAST);
    ovlEn = flashPageSel[`MAD_OVL_BIT];
    infoSel = inWindow && ovlEn;
    infoOff = 9'(pmAddr - `MAD_INFO_BASE);
    if (infoSel) begin
      pmKind = PM_INFO;
    end else if (!flashHit) begin
      pmKind = PM_BLANK;
    end else if (pmAddr < `MAD_PM_RESET_VEC) begin
      pmKind = PM_OPT;
    end else if (pmAddr < `MAD_PM_WDT_VEC) begin
      pmKind = PM_RST;
    end else if (pmAddr < `MAD_PM_TRAP_VEC) begin
      pmKind = PM_WDT;
    end else if (pmAddr < `MAD_PM_IRQ_VEC) begin
      pmKind = PM_TRAP;
    end else if (pmAddr < `MAD_PM_OSC_VEC) begin
      pmKind = PM_IRQ;
    end else if (pmAddr < `MAD_PM_CODE) begin
      pmKind = PM_OSC;
    end else begin
      pmKind = PM_CODE;
    end
  end

  mad_info_rom u_info (
    .offset(infoOff),
    .rdData(infoByte)
  );

  // flash port: no cycle is spent on blank space, and no read cycle while overlaid
  always_comb begin
    flashAddr = pmAddr;
    flashWrData = pmWrData;
    flashRead = pmRead && flashHit && !infoSel;
    // the information area has no write path, so writes only reach flash
    flashWrite = pmWrite && flashHit;
  end

  // program read answer, one cycle after the request
  always_comb begin
    next_pmRdValid = pmRead;
    next_pmRegion = pmRegion;
    next_pmRdData = pmRdData;
    if (pmRead) begin
      next_pmRegion = pmKind;
      if (pmKind == PM_INFO) begin
        next_pmRdData = infoByte;
      end else if (pmKind == PM_BLANK) begin
        next_pmRdData = `MAD_PM_BLANK;
      end else begin
        next_pmRdData = flashRdData;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pmRdData <= `MAD_RESET_BYTE;
      pmRdValid <= 1'b0;
      pmRegion <= PM_BLANK;
    end else begin
      pmRdData <= next_pmRdData;
      pmRdValid <= next_pmRdValid;
      pmRegion <= next_pmRegion;
    end
  end

  // data memory space is absent: reads answer undefined, nothing is stored
  always_comb begin
    next_dmRdValid = dmRead;
    next_dmRdData = `MAD_UNDEF;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dmRdData <= `MAD_RESET_BYTE;
      dmRdValid <= 1'b0;
    end else begin
      dmRdData <= next_dmRdData;
      dmRdValid <= next_dmRdValid;
    end
  end

  // checks
  property p_rf_ram_rdback;
    @(posedge clock) disable iff (!rstn)
    (rfWrite && {1'b0, rfAddr} < RamTop && rfAddr < `MAD_RF_CTL_BASE)
      ##1 (rfRead && !rfWrite && rfAddr == $past(rfAddr))
      |=> (rfRdValid && rfRdData == $past(rfWrData, 2));
  endproperty
  a_rf_ram_rdback: assert property (p_rf_ram_rdback)
    else $error("ram read-back mismatch");

  property p_rf_ctl_route;
    @(posedge clock) disable iff (!rstn)
    (rfAddr >= `MAD_RF_CTL_BASE) |-> (ctlRead == rfRead && ctlWrite == rfWrite);
  endproperty
  a_rf_ctl_route: assert property (p_rf_ctl_route)
    else $error("control page access not routed");

  property p_ctl_reserved;
    @(posedge clock) disable iff (!rstn)
    (rfRead && rfAddr >= `MAD_RF_CTL_BASE && !ctlDecoded)
      |=> (rfRdData == `MAD_UNDEF && rfRegion == RF_CTL);
  endproperty
  a_ctl_reserved: assert property (p_ctl_reserved)
    else $error("reserved control read not undefined");

  property p_rf_hole;
    @(posedge clock) disable iff (!rstn)
    ({1'b0, rfAddr} >= RamTop && rfAddr < `MAD_RF_CTL_BASE)
      |-> (!ramWrEn && !ctlWrite && !ctlRead)
      ##1 ($past(rfRead) -> (rfRdData == `MAD_UNDEF && rfRegion == RF_HOLE));
  endproperty
  a_rf_hole: assert property (p_rf_hole)
    else $error("hole access reached storage");

  property p_pm_blank;
    @(posedge clock) disable iff (!rstn)
    (pmRead && {1'b0, pmAddr} >= FlashTop && !infoSel)
      |-> !flashRead ##1 (pmRdValid && pmRdData == `MAD_PM_BLANK);
  endproperty
  a_pm_blank: assert property (p_pm_blank)
    else $error("unimplemented program read not FFh");

  property p_pm_wr_drop;
    @(posedge clock) disable iff (!rstn)
    ({1'b0, pmAddr} >= FlashTop) |-> !flashWrite;
  endproperty
  a_pm_wr_drop: assert property (p_pm_wr_drop)
    else $error("write beyond flash not dropped");

  property p_pm_vectors;
    @(posedge clock) disable iff (!rstn)
    (pmRead && pmAddr[15:1] == 15'h0001 && flashHit) |=> (pmRegion == PM_RST);
  endproperty
  a_pm_vectors: assert property (p_pm_vectors)
    else $error("reset vector misclassified");

  property p_ovl_on;
    @(posedge clock) disable iff (!rstn)
    (pmRead && flashPageSel[`MAD_OVL_BIT] && pmAddr >= `MAD_INFO_BASE
      && pmAddr <= `MAD_INFO_LAST)
      |-> !flashRead ##1 (pmRegion == PM_INFO && pmRdData == $past(infoByte));
  endproperty
  a_ovl_on: assert property (p_ovl_on)
    else $error("overlay read not from information area");

  // covers both a flash-backed window and the blank one of small parts
  property p_ovl_off;
    @(posedge clock) disable iff (!rstn)
    (pmRead && !flashPageSel[`MAD_OVL_BIT] && inWindow)
      |-> (flashRead == flashHit)
      ##1 (pmRdData == ($past(flashHit) ? $past(flashRdData) : `MAD_PM_BLANK));
  endproperty
  a_ovl_off: assert property (p_ovl_off)
    else $error("window read with overlay off not from flash");

  property p_dm_absent;
    @(posedge clock) disable iff (!rstn)
    dmRead |=> (dmRdValid && dmRdData == `MAD_UNDEF);
  endproperty
  a_dm_absent: assert property (p_dm_absent)
    else $error("data memory read not undefined");
endmodule

//--- hdl/mad_info_rom.sv
// read-only information area image
`timescale 1ns/1ps
`include "mad_params.svh"
module mad_info_rom #(
  parameter logic [511:0] OPTION_BITS = {64{8'hFF}},
  // arbitrary neutral part identifier, left-justified, padded with FFh
  parameter logic [159:0] PART_ID = {"MADDEMO1", {12{8'hFF}}},
  parameter logic [255:0] CAL_DATA = {32{8'hFF}}
) (
  input wire logic [8:0] offset,
  output logic [7:0] rdData
);
  logic [7:0] image [128];

  // image built from constants; there is no write port at all
  for (genvar i = 0; i < 128; i++) begin : g_img
    if (i < `MAD_INFO_PART) begin : g_opt
      assign image[i] = OPTION_BITS[511-8*i -: 8];
    end else if (i < `MAD_INFO_RSVD) begin : g_part
      assign image[i] = PART_ID[159-8*(i-64) -: 8];
    end else if (i < `MAD_INFO_CAL) begin : g_rsvd
      assign image[i] = `MAD_PM_BLANK;
    end else begin : g_cal
      assign image[i] = CAL_DATA[255-8*(i-96) -: 8];
    end
  end

  // upper part of the overlay window is reserved and reads blank
  assign rdData = (offset < `MAD_INFO_BYTES) ? image[offset[6:0]] : `MAD_PM_BLANK;
endmodule

//--- hdl/mad_params.svh
// address map constants for the memory address decoder
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH
`define MAD_RF_AW 12
`define MAD_PM_AW 16
`define MAD_RF_CTL_BASE 12'hF00
`define MAD_RAM_BYTES_DFLT 1024
`define MAD_FLASH_BYTES_DFLT 8192
`define MAD_PM_RESET_VEC 16'h0002
`define MAD_PM_WDT_VEC 16'h0004
`define MAD_PM_TRAP_VEC 16'h0006
`define MAD_PM_IRQ_VEC 16'h0008
`define MAD_PM_OSC_VEC 16'h0038
`define MAD_PM_CODE 16'h003E
`define MAD_INFO_BASE 16'hFE00
`define MAD_INFO_LAST 16'hFF7F
`define MAD_INFO_BYTES 9'h080
`define MAD_INFO_PART 9'h040
`define MAD_INFO_RSVD 9'h054
`define MAD_INFO_CAL 9'h060
`define MAD_OVL_BIT 7
`define MAD_PM_BLANK 8'hFF
`define MAD_UNDEF 8'h00
`define MAD_RESET_BYTE 8'h00
`endif

//--- hdl/mad_pkg.sv
// types shared by the memory address decoder files
package mad_pkg;
  // register file region of the last read, one-hot
  typedef enum logic [2:0] {
    RF_RAM = 3'b001,
    RF_HOLE = 3'b010,
    RF_CTL = 3'b100
  } mad_rf_region_e;
  // program memory region of the last read, one-hot
  typedef enum logic [8:0] {
    PM_OPT = 9'h001,
    PM_RST = 9'h002,
    PM_WDT = 9'h004,
    PM_TRAP = 9'h008,
    PM_IRQ = 9'h010,
    PM_OSC = 9'h020,
    PM_CODE = 9'h040,
    PM_INFO = 9'h080,
    PM_BLANK = 9'h100
  } mad_pm_region_e;
endpackage

//--- hdl/mad_ram.sv
// general-purpose register file ram
`timescale 1ns/1ps
`include "mad_params.svh"
module mad_ram #(
  parameter int BYTES = `MAD_RAM_BYTES_DFLT,
  parameter int AW = $clog2(BYTES)
) (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData
);
  // no reset on the array: contents are undefined at power-up anyway
  logic [7:0] mem [BYTES];

  // asynchronous read, the decoder registers the result
  assign rdData = mem[addr];

  // byte write, only when the decoder has matched the ram range
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
  end
endmodule

//--- tb/mad_mem_model.sv
// flash array and control section answering the decoder
`timescale 1ns/1ps
module mad_mem_model #(
  parameter int FLASH_BYTES = 2048
) (
  input wire logic clock,
  input wire logic [15:0] flashAddr,
  input wire logic flashRead,
  input wire logic flashWrite,
  input wire logic [7:0] flashWrData,
  output logic [7:0] flashRdData,
  input wire logic [7:0] ctlAddr,
  input wire logic ctlRead,
  output logic [7:0] ctlRdData
);
  logic [7:0] mem [FLASH_BYTES];
  logic [7:0] junk = 8'h00;
  initial begin
    for (int i = 0; i < FLASH_BYTES; i++) begin
      mem[i] = 8'(i) ^ 8'hC3;
    end
  end
  // writes land at the edge; nothing here can reach the info area
  always @(posedge clock) begin
    junk <= junk + 8'h1D;
    if (flashWrite) begin
      mem[flashAddr] <= flashWrData;
    end
  end
  // idle lines churn so a stale byte never passes for an answer
  always_comb flashRdData = flashRead ? mem[flashAddr] : junk;
  always_comb ctlRdData = ctlRead ? (ctlAddr ^ 8'h5A) : ~junk;
endmodule

//--- tb/tb_mad_decoder.sv
// self-checking bench for the memory address decoder
`timescale 1ns/1ps
module tb_mad_decoder;
  import mad_pkg::*;
  localparam int RAMB = 512;
  localparam int FLB = 2048;
  localparam logic [15:0] VA [16] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
    16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0037, 16'h0038, 16'h003D, 16'h003E,
    16'h07FF, 16'h0800, 16'hFFFF};
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] rfAddr = 12'h000;
  logic rfRead = 1'b0, rfWrite = 1'b0, ctlDecoded = 1'b1, dmRead = 1'b0;
  logic rfRdValid, ctlRead, ctlWrite, pmRdValid, flashRead, flashWrite, dmRdValid;
  logic [7:0] rfWrData = 8'h00, pmWrData = 8'h00, flashPageSel = 8'h00;
  logic [7:0] rfRdData, ctlAddr, ctlWrData, ctlRdData, pmRdData, flashWrData;
  logic [7:0] flashRdData, dmRdData;
  logic [15:0] pmAddr = 16'h0000;
  logic [15:0] flashAddr;
  logic pmRead = 1'b0, pmWrite = 1'b0;
  mad_rf_region_e rfRegion;
  mad_pm_region_e pmRegion;
  int fail_count = 0, compares = 0, cycles = 0;
  logic [7:0] ramM [RAMB];
  logic [7:0] fm [FLB];
  string nm = "MADDEMO1";

  mad_decoder #(.RAM_BYTES(RAMB), .FLASH_BYTES(FLB)) u_dut (.clock, .rstn, .rfAddr,
    .rfRead, .rfWrite, .rfWrData, .rfRdData, .rfRdValid, .rfRegion, .ctlAddr, .ctlRead,
    .ctlWrite, .ctlWrData, .ctlRdData, .ctlDecoded, .pmAddr, .pmRead, .pmWrite,
    .pmWrData, .pmRdData, .pmRdValid, .pmRegion, .flashPageSel, .flashAddr, .flashRead,
    .flashWrite, .flashWrData, .flashRdData, .dmRead, .dmRdData, .dmRdValid);
  mad_mem_model #(.FLASH_BYTES(FLB)) u_mem (.clock, .flashAddr, .flashRead,
    .flashWrite, .flashWrData, .flashRdData, .ctlAddr, .ctlRead, .ctlRdData);

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one register file access; reads expect the answer one cycle on
  task automatic rfOp(logic wr, logic [11:0] a, logic [7:0] d);
    logic [7:0] e;
    logic [15:0] g;
    @(posedge clock);
    rfAddr <= a;
    rfWrite <= wr;
    rfRead <= !wr;
    rfWrData <= d;
    #1;
    chk({ctlRead, ctlWrite}, {a >= 12'hF00 && !wr, a >= 12'hF00 && wr});
    chk({ctlAddr, ctlWrData}, {a[7:0], d});
    e = (a < RAMB) ? ramM[a] : (a >= 12'hF00 && ctlDecoded) ? a[7:0] ^ 8'h5A : 8'h00;
    g = (a < RAMB) ? RF_RAM : (a >= 12'hF00) ? RF_CTL : RF_HOLE;
    if (wr && a < RAMB) ramM[a] = d;
    @(posedge clock);
    rfRead <= 1'b0;
    rfWrite <= 1'b0;
    #1;
    if (!wr) begin
      chk(rfRdData, e);
      chk(rfRegion, g);
      chk(rfRdValid, 1'b1);
    end
  endtask

  // one program access; overlay state is taken once the request stands
  task automatic pmOp(logic wr, logic [15:0] a, logic [7:0] d);
    logic [7:0] e;
    logic [15:0] g;
    logic ovl;
    @(posedge clock);
    pmAddr <= a;
    pmWrite <= wr;
    pmRead <= !wr;
    pmWrData <= d;
    #1;
    // a page select change made at the call edge has landed by now
    ovl = flashPageSel[7] && a >= 16'hFE00 && a <= 16'hFF7F;
    chk(flashWrite, wr && a < FLB);
    if (ovl) begin
      e = (a >= 16'hFE40 && a < 16'hFE48) ? nm[a - 16'hFE40] : 8'hFF;
      g = PM_INFO;
    end else if (a >= FLB) begin
      e = 8'hFF;
      g = PM_BLANK;
    end else begin
      e = fm[a];
      g = a < 2 ? PM_OPT : a < 4 ? PM_RST : a < 6 ? PM_WDT : a < 8 ? PM_TRAP :
        a < 16'h38 ? PM_IRQ : a < 16'h3E ? PM_OSC : PM_CODE;
    end
    if (wr && a < FLB) fm[a] = d;
    @(posedge clock);
    pmRead <= 1'b0;
    pmWrite <= 1'b0;
    #1;
    if (!wr) begin
      chk({pmRdValid, pmRdData}, {1'b1, e});
      chk(pmRegion, g);
    end
  endtask

  // runaway guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    logic [11:0] a;
    void'($urandom(32'hDD26));
    for (int i = 0; i < FLB; i++) fm[i] = 8'(i) ^ 8'hC3;
    repeat (5) @(posedge clock);
    #1;
    chk({rfRdValid, pmRdValid, rfRdData, pmRdData}, 16'h0000);
    chk({rfRegion, pmRegion}, {RF_HOLE, PM_BLANK});
    @(posedge clock);
    rstn <= 1'b1;
    // ram round trips, hole writes must not alias into ram
    for (int i = 0; i < 40; i++) begin
      a = 12'($urandom_range(RAMB - 1));
      rfOp(1'b1, a, 8'($urandom));
      rfOp(1'b0, a, 8'h00);
      rfOp(1'b1, a + 12'(RAMB), 8'($urandom));
      rfOp(1'b0, a, 8'h00);
      rfOp(1'b0, 12'($urandom_range(12'hEFF, RAMB)), 8'h00);
    end
    rfOp(1'b1, 12'(RAMB - 1), 8'h3C);
    rfOp(1'b0, 12'(RAMB - 1), 8'h00);
    rfOp(1'b0, 12'hEFF, 8'h00);
    // back-to-back write then read of one ram byte, no idle cycle between
    @(posedge clock);
    rfAddr <= 12'h005;
    rfWrite <= 1'b1;
    rfWrData <= 8'hA5;
    @(posedge clock);
    rfWrite <= 1'b0;
    rfRead <= 1'b1;
    ramM[5] = 8'hA5;
    @(posedge clock);
    rfRead <= 1'b0;
    #1;
    chk({rfRdValid, rfRdData}, {1'b1, ramM[5]});
    // control page edges with the decoded flag both ways
    foreach (VA[i]) begin
      @(posedge clock);
      ctlDecoded <= 1'($urandom);
      rfOp(1'($urandom), 12'hF00 + 12'(VA[i][3:0] * 17), 8'($urandom));
      rfOp(1'b0, 12'hF00 + 12'(i * 16), 8'h00);
    end
    rfOp(1'b0, 12'hFFF, 8'h00);
    // vector table edges and blank space
    foreach (VA[i]) pmOp(1'b0, VA[i], 8'h00);
    for (int i = 0; i < 20; i++) begin
      pmOp(1'b1, 16'($urandom_range(FLB - 1)), 8'($urandom));
      pmOp(1'b0, 16'($urandom_range(FLB - 1)), 8'h00);
      pmOp(1'b1, 16'($urandom_range(16'hFFFF, FLB)), 8'($urandom));
      pmOp(1'b0, 16'($urandom_range(16'hFFFF, FLB)), 8'h00);
    end
    // whole overlay window with the enable bit clear, then set
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      flashPageSel <= k ? 8'h80 : 8'h7F;
      for (int j = 16'hFE00; j <= 16'hFF80; j++) pmOp(1'b0, 16'(j), 8'h00);
      pmOp(1'b1, 16'hFE41, 8'h12);
      pmOp(1'b0, 16'hFE41, 8'h00);
    end
    // mid-run reset clears the registered answers left by the last reads
    @(posedge clock);
    rstn <= 1'b0;
    @(posedge clock);
    #1;
    chk({rfRdValid, pmRdValid, rfRdData, pmRdData}, 32'h0);
    chk({rfRegion, pmRegion}, {RF_HOLE, PM_BLANK});
    @(posedge clock);
    rstn <= 1'b1;
    // data memory reaches nothing
    @(posedge clock);
    dmRead <= 1'b1;
    @(posedge clock);
    dmRead <= 1'b0;
    #1;
    chk({dmRdValid, dmRdData}, 16'h0100);
    end_sim();
  end
endmodule
